/* logic/asf_top.sv */
// sample output formatter: register slave, clock-stop detect, cmos and ddr launch
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "asf_defines.svh"

module asf_top
    import asf_pkg::*;
(
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    input  wire logic [3:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic                       parallel_config_pin,
    input  wire logic                       sample_clock,
    input  wire logic [`ASF_SAMPLE_W-1:0]   sample_word,
    output logic      [`ASF_SAMPLE_W-1:0]   cmos_data,
    output logic                            cmos_out_en,
    output logic                            drive_strength_max,
    output logic      [`ASF_PAIRS-1:0]      ddr_rise,
    output logic      [`ASF_PAIRS-1:0]      ddr_fall,
    output logic                            lvds_out_en,
    output logic                            forwarded_sample_clock_rise,
    output logic                            forwarded_sample_clock_fall,
    output logic                            out_clock_shift,
    output logic      [1:0]                 lvds_current_sel,
    output logic                            current_double,
    output logic      [2:0]                 data_pair_resistor_sel,
    output logic      [2:0]                 clock_pair_resistor_sel
);

    // ---------------- system clock domain ----------------

    logic [`ASF_CTRL_W-1:0]   ctrl_reg;
    logic                     waitreq_reg;
    logic [31:0]              readdata_reg;
    logic                     pin_meta_reg;
    logic                     pin_sync_reg;
    logic                     act_meta_reg;
    logic                     act_sync_reg;
    logic                     act_prev_reg;
    logic [`ASF_STOP_W-1:0]   gap_reg;
    logic                     stopped_reg;
    asf_wake_t                wake_reg;
    logic [`ASF_SETTLE_W-1:0] settle_reg;
    asf_cfg_t                 cfg_hold_reg;
    asf_cfg_t                 cfg_want;
    logic                     req_reg;
    logic                     ack_meta_reg;
    logic                     ack_sync_reg;
    logic                     eff_ddr;
    logic                     eff_offset;
    asf_status_t              status;
    // sample-side flops, read here only through two-flop synchronisers
    logic                     smp_toggle_reg;
    logic                     smp_seen_reg;

    // pin from outside the domain
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= parallel_config_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // pin high selects ddr and offset binary when the pin is in charge
    always_comb begin
        if (ctrl_reg[`ASF_CTRL_USE_PIN]) begin
            eff_ddr    = pin_sync_reg;
            eff_offset = pin_sync_reg;
        end else begin
            eff_ddr    = ctrl_reg[`ASF_CTRL_DDR];
            eff_offset = ctrl_reg[`ASF_CTRL_OFFSET];
        end
    end

    // bus slave: one wait cycle, answer on the second edge
    // readiness never depends on the address, so unmapped reads answer too
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            waitreq_reg <= 1'b1;
        end else if (!waitreq_reg) begin
            waitreq_reg <= 1'b1;
        end else if (avs_read || avs_write) begin
            waitreq_reg <= 1'b0;
        end
    end

    // status word as software reads it
    always_comb begin
        status.offset_binary = eff_offset;
        status.ddr_mode      = eff_ddr;
        status.valid         = (wake_reg == WAKE_RUN);
        status.stopped       = stopped_reg;
    end

    // read data loaded as the request is taken, so it stands at the answer edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            readdata_reg <= 32'h0;
        end else if (avs_read && waitreq_reg) begin
            case (avs_address)
                `ASF_CTRL_ADDR:   readdata_reg <= {17'h0, ctrl_reg};
                `ASF_STATUS_ADDR: readdata_reg <= {28'h0, status};
                default:          readdata_reg <= 32'h0;
            endcase
        end
    end

    // write lands at the answer edge; lanes two and three are ignored
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_reg <= `ASF_CTRL_RESET;
        end else if (avs_write && !waitreq_reg && avs_address == `ASF_CTRL_ADDR) begin
            if (avs_byteenable[0]) begin
                ctrl_reg[`ASF_B0_HI:`ASF_B0_LO] <= avs_writedata[`ASF_B0_HI:`ASF_B0_LO];
            end
            if (avs_byteenable[1]) begin
                ctrl_reg[`ASF_CTRL_HI:`ASF_B1_LO] <= avs_writedata[`ASF_CTRL_HI:`ASF_B1_LO];
            end
        end
    end

    assign avs_waitrequest = waitreq_reg;
    assign avs_readdata    = readdata_reg;

    // sample clock activity, seen as a toggle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            act_meta_reg <= 1'b0;
            act_sync_reg <= 1'b0;
            act_prev_reg <= 1'b0;
        end else begin
            act_meta_reg <= smp_toggle_reg;
            act_sync_reg <= act_meta_reg;
            act_prev_reg <= act_sync_reg;
        end
    end

    // no sample edge for a full minimum-rate period means stopped
    // counter parks at the window end while stopped, so it never wraps
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gap_reg     <= '0;
            stopped_reg <= 1'b1;
        end else if (act_sync_reg != act_prev_reg) begin
            gap_reg     <= '0;
            stopped_reg <= 1'b0;
        end else if (gap_reg == `ASF_STOP_W'(`ASF_STOP_CYCLES - 1)) begin
            stopped_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + `ASF_STOP_W'(1);
        end
    end

    // wake sequence after the clock returns
    // settle far below the wake bound, leaving room for the sync delays
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wake_reg   <= WAKE_STOPPED;
            settle_reg <= '0;
        end else begin
            case (wake_reg)
                WAKE_STOPPED: begin
                    settle_reg <= '0;
                    if (!stopped_reg) begin
                        wake_reg <= WAKE_SETTLE;
                    end
                end
                WAKE_SETTLE: begin
                    if (stopped_reg) begin
                        wake_reg <= WAKE_STOPPED;
                    end else if (settle_reg == `ASF_SETTLE_W'(`ASF_SETTLE_CYCLES - 1)) begin
                        wake_reg <= WAKE_RUN;
                    end else begin
                        settle_reg <= settle_reg + `ASF_SETTLE_W'(1);
                    end
                end
                WAKE_RUN: begin
                    if (stopped_reg) begin
                        wake_reg <= WAKE_STOPPED;
                    end
                end
                default: begin
                    wake_reg <= WAKE_STOPPED;
                end
            endcase
        end
    end

    // settings wanted now; valid rides along so the outputs blank whole, from the fourth sample edge after the clock returns
    always_comb begin
        cfg_want.valid         = (wake_reg == WAKE_RUN);
        cfg_want.ddr_mode      = eff_ddr;
        cfg_want.offset_binary = eff_offset;
        cfg_want.clk_shift     = ctrl_reg[`ASF_CTRL_CLK_SHIFT];
        cfg_want.drive_max     = ctrl_reg[`ASF_CTRL_DRIVE_MAX];
        cfg_want.lvds_cur      = ctrl_reg[`ASF_CTRL_CUR_HI:`ASF_CTRL_CUR_LO];
        cfg_want.cur_double    = ctrl_reg[`ASF_CTRL_CUR_DBL];
        cfg_want.data_term     = ctrl_reg[`ASF_CTRL_DTERM_HI:`ASF_CTRL_DTERM_LO];
        cfg_want.clock_term    = ctrl_reg[`ASF_CTRL_CTERM_HI:`ASF_CTRL_CTERM_LO];
    end

    // toggle handshake: hold word stays put until the sample side answers
    // a multi-bit word must not move while the far side may be copying it
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ack_meta_reg <= 1'b0;
            ack_sync_reg <= 1'b0;
        end else begin
            ack_meta_reg <= smp_seen_reg;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfg_hold_reg <= '0;
            req_reg      <= 1'b0;
        end else if (req_reg == ack_sync_reg && cfg_want != cfg_hold_reg) begin
            cfg_hold_reg <= cfg_want;
            req_reg      <= ~req_reg;
        end
    end

    // ---------------- sample clock domain ----------------

    logic                     smp_rst_meta_reg;
    logic                     smp_rst_reg;
    logic                     smp_req_meta_reg;
    logic                     smp_req_sync_reg;
    asf_cfg_t                 cfg_act_reg;
    logic [`ASF_SAMPLE_W-1:0] fmt_word;
    logic [`ASF_PADDED_W-1:0] padded_word;

    // reset reaches the sample side through two flops, so it needs three sample edges
    always_ff @(posedge sample_clock) begin
        smp_rst_meta_reg <= sys_rst;
        smp_rst_reg      <= smp_rst_meta_reg;
    end

    always_ff @(posedge sample_clock) begin
        if (smp_rst_reg) begin
            smp_toggle_reg <= 1'b0;
        end else begin
            smp_toggle_reg <= ~smp_toggle_reg;
        end
    end

    always_ff @(posedge sample_clock) begin
        if (smp_rst_reg) begin
            smp_req_meta_reg <= 1'b0;
            smp_req_sync_reg <= 1'b0;
        end else begin
            smp_req_meta_reg <= req_reg;
            smp_req_sync_reg <= smp_req_meta_reg;
        end
    end

    // new settings taken whole at one sample edge
    always_ff @(posedge sample_clock) begin
        if (smp_rst_reg) begin
            smp_seen_reg <= 1'b0;
            cfg_act_reg  <= '0;
        end else if (smp_req_sync_reg != smp_seen_reg) begin
            smp_seen_reg <= smp_req_sync_reg;
            cfg_act_reg  <= cfg_hold_reg;
        end
    end

    // pair six carries the absent bits twelve and thirteen as zero
    always_comb begin
        if (cfg_act_reg.offset_binary) begin
            fmt_word = {~sample_word[`ASF_MSB], sample_word[`ASF_MSB-1:0]};
        end else begin
            fmt_word = sample_word;
        end
        padded_word = {2'h0, fmt_word};
    end

    // cmos word, one pin per bit, refreshed each sample edge
    always_ff @(posedge sample_clock) begin
        if (smp_rst_reg) begin
            cmos_data   <= '0;
            cmos_out_en <= 1'b0;
        end else if (cfg_act_reg.valid && !cfg_act_reg.ddr_mode) begin
            cmos_data   <= fmt_word;
            cmos_out_en <= 1'b1;
        end else begin
            cmos_data   <= '0;
            cmos_out_en <= 1'b0;
        end
    end

    // ddr halves for the output cells: rise half even bits, fall half odd bits
    // all seven pairs are driven, the top one as zero
    always_ff @(posedge sample_clock) begin
        if (smp_rst_reg) begin
            ddr_rise    <= '0;
            ddr_fall    <= '0;
            lvds_out_en <= 1'b0;
        end else if (cfg_act_reg.valid && cfg_act_reg.ddr_mode) begin
            for (int k = 0; k < `ASF_PAIRS; k++) begin
                ddr_rise[k] <= padded_word[2*k];
                ddr_fall[k] <= padded_word[2*k+1];
            end
            lvds_out_en <= 1'b1;
        end else begin
            ddr_rise    <= '0;
            ddr_fall    <= '0;
            lvds_out_en <= 1'b0;
        end
    end

    // forwarded clock halves: high in the first half, low in the second
    // a settling link keeps its clock pair low; while the sample clock is stopped the halves hold their last values
    always_ff @(posedge sample_clock) begin
        if (smp_rst_reg) begin
            forwarded_sample_clock_rise <= 1'b0;
            forwarded_sample_clock_fall <= 1'b0;
        end else begin
            forwarded_sample_clock_rise <= cfg_act_reg.valid;
            forwarded_sample_clock_fall <= 1'b0;
        end
    end

    // buffer settings follow the word they belong to
    // same edge as the data, so no word meets mixed settings
    always_ff @(posedge sample_clock) begin
        if (smp_rst_reg) begin
            out_clock_shift         <= 1'b0;
            drive_strength_max      <= 1'b0;
            lvds_current_sel        <= '0;
            current_double          <= 1'b0;
            data_pair_resistor_sel  <= '0;
            clock_pair_resistor_sel <= '0;
        end else begin
            out_clock_shift         <= cfg_act_reg.clk_shift;
            drive_strength_max      <= cfg_act_reg.drive_max;
            lvds_current_sel        <= cfg_act_reg.lvds_cur;
            current_double          <= cfg_act_reg.cur_double;
            data_pair_resistor_sel  <= cfg_act_reg.data_term;
            clock_pair_resistor_sel <= cfg_act_reg.clock_term;
        end
    end

endmodule // asf_top

/* inc/asf_defines.svh */
// constants for the sample output formatter
`ifndef ASF_DEFINES_SVH
`define ASF_DEFINES_SVH
`define ASF_SYS_CLK_NS     40
`define ASF_MIN_RATE_MSPS  1
`define ASF_STOP_NS        (1000 / `ASF_MIN_RATE_MSPS)
`define ASF_STOP_CYCLES    ((`ASF_STOP_NS + `ASF_SYS_CLK_NS - 1) / `ASF_SYS_CLK_NS)
`define ASF_STOP_W         5
`define ASF_WAKE_US        50
`define ASF_WAKE_CYCLES    ((`ASF_WAKE_US * 1000) / `ASF_SYS_CLK_NS)
`define ASF_SETTLE_CYCLES  (`ASF_WAKE_CYCLES / 16)
`define ASF_SETTLE_W       7
`define ASF_CTRL_ADDR      4'h0
`define ASF_STATUS_ADDR    4'h4
`define ASF_CTRL_W         15
`define ASF_CTRL_RESET     15'h0000
`define ASF_B0_LO          0
`define ASF_B0_HI          7
`define ASF_B1_LO          8
`define ASF_CTRL_HI        14
`define ASF_CTRL_DDR       0
`define ASF_CTRL_OFFSET    1
`define ASF_CTRL_USE_PIN   2
`define ASF_CTRL_CLK_SHIFT 3
`define ASF_CTRL_DRIVE_MAX 4
`define ASF_CTRL_CUR_LO    5
`define ASF_CTRL_CUR_HI    6
`define ASF_CTRL_CUR_DBL   7
`define ASF_CTRL_DTERM_LO  8
`define ASF_CTRL_DTERM_HI  10
`define ASF_CTRL_CTERM_LO  11
`define ASF_CTRL_CTERM_HI  13
`define ASF_SAMPLE_W       12
`define ASF_MSB            11
`define ASF_PAIRS          7
`define ASF_PADDED_W       14
`endif

/* inc/asf_pkg.sv */
// types for the sample output formatter
package asf_pkg;
    typedef struct packed {
        logic       valid;
        logic       ddr_mode;
        logic       offset_binary;
        logic       clk_shift;
        logic       drive_max;
        logic [1:0] lvds_cur;
        logic       cur_double;
        logic [2:0] data_term;
        logic [2:0] clock_term;
    } asf_cfg_t;

    typedef struct packed {
        logic offset_binary;
        logic ddr_mode;
        logic valid;
        logic stopped;
    } asf_status_t;

    typedef enum logic [1:0] {
        WAKE_STOPPED,
        WAKE_SETTLE,
        WAKE_RUN
    } asf_wake_t;
endpackage

/* sim/asf_top_asserts.sv */
// port checks for the sample output formatter
`timescale 1ns/1ps
`include "asf_defines.svh"

module asf_top_asserts
    import asf_pkg::*;
(
    input wire logic                     clock,
    input wire logic                     sys_rst,
    input wire logic [3:0]               avs_address,
    input wire logic                     avs_read,
    input wire logic                     avs_write,
    input wire logic [31:0]              avs_readdata,
    input wire logic                     avs_waitrequest,
    input wire logic                     sample_clock,
    input wire logic [`ASF_SAMPLE_W-1:0] sample_word,
    input wire logic [`ASF_SAMPLE_W-1:0] cmos_data,
    input wire logic                     cmos_out_en,
    input wire logic [`ASF_PAIRS-1:0]    ddr_rise,
    input wire logic [`ASF_PAIRS-1:0]    ddr_fall,
    input wire logic                     lvds_out_en,
    input wire logic                     forwarded_sample_clock_rise,
    input wire logic                     forwarded_sample_clock_fall
);
    logic [`ASF_SAMPLE_W-1:0] sw_q;

    // word taken at the previous sample edge
    always_ff @(posedge sample_clock) begin
        sw_q <= sample_word;
    end

    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    chk_bus_answer: assert property (@(posedge clock) disable iff (sys_rst)
        s_req |=> s_ack) else $error("bus answer not one wait cycle");
    chk_bus_idle: assert property (@(posedge clock) disable iff (sys_rst)
        !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest dropped without request");
    chk_unmapped_zero: assert property (@(posedge clock) disable iff (sys_rst)
        avs_read && !avs_waitrequest && avs_address != 4'h0 && avs_address != 4'h4
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    chk_one_mode: assert property (@(posedge sample_clock) disable iff (sys_rst)
        !(cmos_out_en && lvds_out_en)) else $error("both output modes enabled");
    chk_cmos_quiet: assert property (@(posedge sample_clock) disable iff (sys_rst)
        !cmos_out_en |-> cmos_data == 12'h000) else $error("cmos data while off");
    chk_cmos_word: assert property (@(posedge sample_clock) disable iff (sys_rst)
        cmos_out_en |-> cmos_data[10:0] == sw_q[10:0]) else $error("cmos word wrong");
    chk_ddr_split: assert property (@(posedge sample_clock) disable iff (sys_rst)
        lvds_out_en |-> ddr_rise[5:0] == {sw_q[10], sw_q[8], sw_q[6], sw_q[4], sw_q[2],
        sw_q[0]} && ddr_fall[4:0] == {sw_q[9], sw_q[7], sw_q[5], sw_q[3], sw_q[1]})
        else $error("ddr bit split wrong");
    chk_pair_six: assert property (@(posedge sample_clock) disable iff (sys_rst)
        ddr_rise[6] == 1'b0 && ddr_fall[6] == 1'b0) else $error("pair six not idle");
    chk_fwd_clock: assert property (@(posedge sample_clock) disable iff (sys_rst)
        forwarded_sample_clock_rise == (cmos_out_en || lvds_out_en)
        && !forwarded_sample_clock_fall) else $error("forwarded clock halves wrong");
endmodule // asf_top_asserts

/* sim/asf_rx_model.sv */
// capture receiver at the far side of the output pins
`timescale 1ns/1ps
`include "asf_defines.svh"

module asf_rx_model
    import asf_pkg::*;
(
    input  wire logic                     sample_clock,
    input  wire logic [`ASF_SAMPLE_W-1:0] cmos_data,
    input  wire logic                     cmos_out_en,
    input  wire logic [`ASF_PAIRS-1:0]    ddr_rise,
    input  wire logic [`ASF_PAIRS-1:0]    ddr_fall,
    input  wire logic                     lvds_out_en,
    input  wire logic                     forwarded_sample_clock_rise,
    output logic      [`ASF_SAMPLE_W-1:0] rx_word
);
    // stale capture toggles so an idle link never matches on two edges running
    always_ff @(posedge sample_clock) begin
        if (forwarded_sample_clock_rise && cmos_out_en) begin
            rx_word <= cmos_data;
        end else if (forwarded_sample_clock_rise && lvds_out_en) begin
            for (int k = 0; k < 6; k++) begin
                rx_word[2*k]   <= ddr_rise[k];
                rx_word[2*k+1] <= ddr_fall[k];
            end
        end else begin
            rx_word <= ~rx_word;
        end
    end
endmodule // asf_rx_model

/* sim/adc_sample_output_formatter_tb.sv */
// bench for the sample output formatter
`timescale 1ns/1ps
`include "asf_defines.svh"

module adc_sample_output_formatter_tb
    import asf_pkg::*;
;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, cmos_out_en, drive_strength_max, lvds_out_en;
    logic        parallel_config_pin = 1'b0;
    logic        sample_clock = 1'b0;
    logic        sclk_run = 1'b1;
    logic [11:0] sample_word = 12'h000;
    logic [11:0] cmos_data, rx_word;
    logic [6:0]  ddr_rise, ddr_fall;
    logic        fwd_rise, fwd_fall, out_clock_shift, current_double;
    logic [1:0]  lvds_current_sel;
    logic [2:0]  data_pair_resistor_sel, clock_pair_resistor_sel;
    logic [11:0] words [4] = '{12'h000, 12'h7ff, 12'h800, 12'ha5c};
    int          errors = 0;
    int          checks_done = 0;

    asf_top DUT (
        .clock, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .parallel_config_pin,
        .sample_clock, .sample_word, .cmos_data, .cmos_out_en, .drive_strength_max,
        .ddr_rise, .ddr_fall, .lvds_out_en, .forwarded_sample_clock_rise(fwd_rise),
        .forwarded_sample_clock_fall(fwd_fall), .out_clock_shift, .lvds_current_sel,
        .current_double, .data_pair_resistor_sel, .clock_pair_resistor_sel
    );
    asf_rx_model u_rx (
        .sample_clock, .cmos_data, .cmos_out_en, .ddr_rise, .ddr_fall, .lvds_out_en,
        .forwarded_sample_clock_rise(fwd_rise), .rx_word
    );

    always #20 clock = ~clock;
    // link clock stands still while stopped
    initial begin
        #7;
        forever #16 if (sclk_run) sample_clock = ~sample_clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        @(posedge clock);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= !wr;
        avs_write      <= wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            errors++;
            end_of_test();
        end
    endtask

    // poll status within the wake-up bound of 1250 cycles
    task automatic wait_valid();
        int n;
        n = 0;
        do begin
            bus(1'b0, 4'h4, 32'h0, 4'h0);
            n += 3;
        end while (rd[1] !== 1'b1 && n < 1250);
        check(rd & 32'h2, 32'h2);
        if (rd[1] !== 1'b1) begin
            end_of_test();
        end
    endtask

    task automatic send(input logic [11:0] w, input logic off);
        @(posedge sample_clock);
        sample_word <= w;
        repeat (3) @(posedge sample_clock);
        #1;
        check({20'h0, rx_word}, {20'h0, off ? {~w[11], w[10:0]} : w});
    endtask

    initial begin : main
        logic [31:0] c;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        bus(1'b0, 4'h0, 32'h0, 4'h0);
        check(rd, 32'h0);
        bus(1'b1, 4'h0, 32'h7fff, 4'h1);
        bus(1'b0, 4'h0, 32'h0, 4'h0);
        check(rd, 32'hff);
        bus(1'b1, 4'h8, 32'h7fff, 4'hf);
        bus(1'b0, 4'h8, 32'h0, 4'h0);
        check(rd, 32'h0);
        bus(1'b0, 4'h0, 32'h0, 4'h0);
        check(rd, 32'hff);
        bus(1'b1, 4'h0, 32'h0, 4'hf);
        wait_valid();
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            c = {18'h0, 3'(7 - i), 3'(i), i[0], 2'(i), i[1], i[2], 3'h0};
            bus(1'b1, 4'h0, c, 4'hf);
            repeat (8) @(posedge sample_clock);
            #1;
            check({21'h0, clock_pair_resistor_sel, data_pair_resistor_sel, current_double,
                   lvds_current_sel, drive_strength_max, out_clock_shift},
                  {21'h0, c[13:3]});
        end
        $display("test settings done");
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 4'h0, 32'(m), 4'hf);
            repeat (8) @(posedge sample_clock);
            #1;
            check({31'h0, lvds_out_en}, 32'(m & 1));
            foreach (words[j]) send(words[j], m[1]);
        end
        bus(1'b1, 4'h0, 32'h4, 4'hf);
        for (int p = 1; p >= 0; p--) begin
            @(posedge clock);
            parallel_config_pin <= p[0];
            // pin sync and a pending handshake add to the settings delay
            repeat (16) @(posedge sample_clock);
            #1;
            check({31'h0, lvds_out_en}, 32'(p));
            send(12'h123, p[0]);
        end
        $display("test modes done");
        sclk_run = 1'b0;
        repeat (40) @(posedge clock);
        bus(1'b0, 4'h4, 32'h0, 4'h0);
        check(rd & 32'h3, 32'h1);
        sclk_run = 1'b1;
        wait_valid();
        check(rd & 32'h1, 32'h0);
        send(12'h5a5, 1'b0);
        $display("test clock stop done");
        end_of_test();
    end

    // whole-run limit, counted as a mismatch
    initial begin : watchdog
        repeat (60000) @(posedge clock);
        errors++;
        end_of_test();
    end
endmodule // adc_sample_output_formatter_tb

bind asf_top asf_top_asserts u_chk (
    .clock, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .sample_clock, .sample_word, .cmos_data, .cmos_out_en,
    .ddr_rise, .ddr_fall, .lvds_out_en, .forwarded_sample_clock_rise,
    .forwarded_sample_clock_fall
);
